// ### core/hbrfe_regs.vh
`ifndef HBRFE_REGS_VH
`define HBRFE_REGS_VH
// -----------------------------------------------------------------
// Widths and reset values
// -----------------------------------------------------------------
`define HBRFE_DW 8
`define HBRFE_DATA_RST 8'h00
`define HBRFE_SYNC_ZERO 2'h0
// -----------------------------------------------------------------
// Front-end states
// -----------------------------------------------------------------
`define HBRFE_ST_RESET 2'h0
`define HBRFE_ST_WAKE 2'h1
`define HBRFE_ST_RUN 2'h2
`endif

// ### core/hbrfe_sync.v
`include "hbrfe_regs.vh"

module hbrfe_sync
(
    // Clock
    input wire clk,
    // Async level in, synchronised level out
    input wire din,
    output wire dout
);

reg [1:0] s_q;

// First flop feeds only the second
always @(posedge clk)
begin
    s_q <= {s_q[0], din};
end

assign dout = s_q[1];

endmodule

// ### core/hbrfe_top.v
`include "hbrfe_regs.vh"

module hbrfe_top
(
    // Clock and reset
    input wire REF_CLK,
    input wire RST_B,
    // Host side
    input wire HOST_RESET_N,
    input wire RETAIN_EN,
    input wire WR_EN,
    input wire [7:0] WR_DATA,
    // Register output and pin drive
    output reg [7:0] RD_DATA,
    output reg [7:0] PIN_OUT,
    output reg PIN_OE,
    output reg READY
);

// -----------------------------------------------------------------
// Input synchronisers
// -----------------------------------------------------------------
wire host_rst_n_s;
wire retain_s;

hbrfe_sync u_rst_sync
(
    .clk(REF_CLK),
    .din(HOST_RESET_N),
    .dout(host_rst_n_s)
);

hbrfe_sync u_ret_sync
(
    .clk(REF_CLK),
    .din(RETAIN_EN),
    .dout(retain_s)
);

// -----------------------------------------------------------------
// Host reset qualification
// -----------------------------------------------------------------
// Assertion acts on the raw pin so drivers float at the next REF_CLK edge; release
// waits for the synchronised level to avoid a metastable exit.
wire host_in_reset;
assign host_in_reset = ~HOST_RESET_N | ~host_rst_n_s;

reg [1:0] state_q;
reg [1:0] state_d;
reg [7:0] data_q;
reg [7:0] data_d;

always @*
begin
    state_d = state_q;
    case (state_q)
        `HBRFE_ST_RESET:
        begin
            if (!host_in_reset)
                state_d = `HBRFE_ST_WAKE;
        end
        `HBRFE_ST_WAKE:
        begin
            state_d = `HBRFE_ST_RUN;
        end
        `HBRFE_ST_RUN:
        begin
            if (host_in_reset)
                state_d = `HBRFE_ST_RESET;
        end
        default:
        begin
            state_d = `HBRFE_ST_RESET;
        end
    endcase
    if (host_in_reset)
        state_d = `HBRFE_ST_RESET;
end

// -----------------------------------------------------------------
// Internal register
// -----------------------------------------------------------------
// Retention only guards against host reset; RST_B always clears.
always @*
begin
    data_d = data_q;
    if (host_in_reset)
    begin
        if (!retain_s)
            data_d = `HBRFE_DATA_RST;
    end
    else if (WR_EN && state_q == `HBRFE_ST_RUN)
        data_d = WR_DATA;
end

// Inputs sampled on the rising edge only
always @(posedge REF_CLK)
begin
    if (!RST_B)
    begin
        state_q <= `HBRFE_ST_RESET;
        data_q <= `HBRFE_DATA_RST;
        RD_DATA <= `HBRFE_DATA_RST;
        PIN_OUT <= `HBRFE_DATA_RST;
        PIN_OE <= 1'b0;
        READY <= 1'b0;
    end
    else
    begin
        state_q <= state_d;
        data_q <= data_d;
        RD_DATA <= data_d;
        PIN_OUT <= data_d;
        PIN_OE <= (state_d == `HBRFE_ST_RUN);
        READY <= (state_d == `HBRFE_ST_RUN);
    end
end

endmodule

// ### testbench/hbrfe_asserts.sv
module hbrfe_asserts(
    input wire REF_CLK, RST_B, HOST_RESET_N, RETAIN_EN, WR_EN, READY, PIN_OE,
    input wire [7:0] WR_DATA, RD_DATA);
    timeunit 1ns / 1ns;
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RST_B);
    pins_off_a: assert property (!HOST_RESET_N |=> !PIN_OE & !READY) else $error("o");
    data_clr_a: assert property ((!HOST_RESET_N & !RETAIN_EN)[*3] |=> !RD_DATA)
        else $error("c");
    data_keep_a: assert property ((!HOST_RESET_N & RETAIN_EN)[*3] |=> $stable(RD_DATA))
        else $error("k");
    sync_wake_a: assert property ($rose(HOST_RESET_N) |-> !READY ##1 !READY)
        else $error("w");
    run_up_a: assert property ($rose(HOST_RESET_N) ##1 HOST_RESET_N[*5] |-> READY & PIN_OE)
        else $error("u");
    wr_take_a: assert property (WR_EN & READY & HOST_RESET_N |=> RD_DATA == $past(WR_DATA))
        else $error("w");
    cover property ($rose(READY));
    cover property (WR_EN & READY);
    cover property (!HOST_RESET_N & RETAIN_EN);
endmodule

// ### testbench/hbrfe_host.sv
module hbrfe_host(
    input wire REF_CLK, HOLD,
    output logic HOST_RESET_N);
    timeunit 1ns / 1ns;
    // Reset moves only on a clock edge, as from a host reset tree
    always @(posedge REF_CLK) HOST_RESET_N <= !HOLD;
endmodule

// ### testbench/hbrfe_top_test.sv
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin mismatches++; $display("[FAIL] %0t bad", $time); end end
module hbrfe_top_test;
    timeunit 1ns / 1ns;
    logic REF_CLK = 0, RST_B = 0, HOLD = 0, RETAIN_EN = 0, WR_EN = 0;
    logic [7:0] WR_DATA = 8'h5A;
    wire HOST_RESET_N, READY, PIN_OE;
    wire [7:0] RD_DATA, PIN_OUT;
    int mismatches = 0, check_count = 0;
    initial forever #25 REF_CLK = ~REF_CLK;
    hbrfe_host hbrfe_host_inst(.*);
    hbrfe_top hbrfe_top_inst(.*);
    task summarize;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Writes stay on until HOLD drops, before HOST_RESET_N rises, so a leak during the host reset shows
    task t_cycle(input logic k);
        RETAIN_EN <= k;
        WR_EN <= 1'h1;
        @(posedge REF_CLK) HOLD <= 1'h1;
        #1 `CHK(PIN_OUT, 8'h5A)
        repeat (5) @(posedge REF_CLK);
        HOLD <= 1'h0;
        WR_EN <= 1'h0;
        #1 `CHK({PIN_OE, READY, RD_DATA}, {2'h0, 8'h5A & {8{k}}})
        repeat (7) @(posedge REF_CLK);
        #1 `CHK({PIN_OE, READY, RD_DATA}, {2'h3, 8'h5A & {8{k}}})
        $display("cycle done");
    endtask
    initial
    begin
        repeat (3) @(posedge REF_CLK);
        RST_B <= 1'h1;
        repeat (6) @(posedge REF_CLK);
        t_cycle(1'h0);
        t_cycle(1'h1);
        summarize;
    end
endmodule
bind hbrfe_top hbrfe_asserts hbrfe_asserts_inst(.*);
